// [hdl/sfmc_ctrl.sv]
/*
  Framed-mode control: control registers, bit-clock prescaler and frame
  sync generation (master) or detection (slave) on the select pin.
  Assumes a plain register port on clk_sys and an external serial peer
  whose sync pin is asynchronous to clk_sys.
*/
`timescale 1ns/1ps
`include "sfmc_defs.svh"

module sfmc_ctrl (
  // Clock and reset
  input  wire logic                     clk_sys,
  input  wire logic                     rstn,
  // Register port
  input  wire logic [`SFMC_ADDR_W-1:0]  reg_addr,
  input  wire logic [15:0]              reg_wdata,
  input  wire logic                     reg_wr,
  input  wire logic                     reg_rd,
  output logic      [15:0]              reg_rdata,
  // Frame start request from the shift engine
  input  wire logic                     frame_req,
  // Select pin as frame sync
  input  wire logic                     sync_pin_in,
  output logic                          sync_pin_out,
  output logic                          sync_pin_oe,
  // Bit timing towards the shift engine
  output logic                          bit_tick,
  output logic                          frame_start,
  output logic      [4:0]               frame_bits
);

  // Registered state
  logic [15:0]           ctrl1_reg;
  logic [15:0]           ctrl1_next;
  logic [15:0]           ctrl2_reg;
  logic [15:0]           ctrl2_next;
  logic [8:0]            div_cnt_reg;
  logic [8:0]            div_cnt_next;
  logic [4:0]            bit_cnt_reg;
  logic [4:0]            bit_cnt_next;
  logic                  sync_out_reg;
  logic                  sync_out_next;
  logic                  sync_s1_reg;
  logic                  sync_s2_reg;
  logic                  sync_s3_reg;
  logic                  start_reg;
  logic                  start_next;
  logic [15:0]           rdata_reg;
  logic [15:0]           rdata_next;
  sfmc_pkg::sfmc_state_e state_reg;
  sfmc_pkg::sfmc_state_e state_next;

  // Decode and datapath
  sfmc_pkg::sfmc_cfg_s   cfg;
  wire logic [1:0]       ppre = ctrl1_reg[`SFMC_PPRE_LSB +: 2];
  wire logic [2:0]       spre = ctrl1_reg[`SFMC_SPRE_LSB +: 3];
  wire logic [8:0]       pdiv;
  wire logic [8:0]       sdiv;
  wire logic [8:0]       full_div;
  wire logic             tick;
  wire logic             div_clr;
  wire logic             last_bit;
  wire logic             busy;
  wire logic [15:0]      stat_word;
  wire logic             sync_act;
  wire logic             sync_edge_in;
  wire logic             master;
  wire logic             wr_c1;
  wire logic             wr_c2;
  wire logic             sel_c1;
  wire logic             sel_c2;
  wire logic             sel_st;

  assign cfg.frm_en    = ctrl2_reg[`SFMC_BIT_FRAMED_EN];
  assign cfg.sync_dir  = ctrl2_reg[`SFMC_BIT_DIR];
  assign cfg.sync_pol  = ctrl2_reg[`SFMC_BIT_POL];
  assign cfg.sync_edge = ctrl2_reg[`SFMC_BIT_EDGE];

  assign pdiv = (ppre == `SFMC_PPRE_64) ? `SFMC_DIV_64 :
                (ppre == `SFMC_PPRE_16) ? `SFMC_DIV_16 :
                (ppre == `SFMC_PPRE_4)  ? `SFMC_DIV_4  : `SFMC_DIV_1;
  // Secondary code 111 is 1:1, 000 is 8:1
  assign sdiv     = 9'(4'h8 - {1'b0, spre});
  // relies on software
  // 64 x 8 wraps to zero; compare at all-ones still spans 512
  assign full_div = 9'(pdiv * sdiv);
  assign tick     = (div_cnt_reg == 9'(full_div - 9'h001));

  assign frame_bits = ctrl1_reg[`SFMC_BIT_WORD16] ? `SFMC_BITS_16 : `SFMC_BITS_8;

  assign master = cfg.frm_en & ~cfg.sync_dir;
  assign sync_act     = sync_s2_reg ^ ~cfg.sync_pol;
  // Edge on the synchronised level, never on the raw pin
  assign sync_edge_in = sync_act & ~(sync_s3_reg ^ ~cfg.sync_pol);

  assign sync_pin_out = sync_out_reg ^ ~cfg.sync_pol;
  // pin drive only when framed master
  assign sync_pin_oe  = master;
  // Ticks only while a frame runs
  assign bit_tick     = tick & busy;
  assign frame_start  = start_reg;
  assign reg_rdata    = rdata_reg;

  // Register decode
  assign sel_c1 = (reg_addr == `SFMC_OFS_CTRL1);
  assign sel_c2 = (reg_addr == `SFMC_OFS_CTRL2);
  assign sel_st = (reg_addr == `SFMC_OFS_STAT);
  assign wr_c1  = reg_wr & sel_c1;
  assign wr_c2  = reg_wr & sel_c2;

  // Status: busy, synchronised sync level, state
  assign busy      = (state_reg != sfmc_pkg::SFMC_IDLE);
  assign stat_word = {11'h000, busy, sync_act, 1'b0, state_reg};

  // CTRL2 bit zero not stored; kept by software
  assign ctrl1_next = wr_c1 ? (reg_wdata & `SFMC_CTRL1_WMASK) : ctrl1_reg;
  assign ctrl2_next = wr_c2 ? (reg_wdata & `SFMC_CTRL2_WMASK) : ctrl2_reg;
  // Read data only in the cycle after the strobe
  assign rdata_next = ~reg_rd ? 16'h0000 :
                      sel_c1  ? ctrl1_reg :
                      sel_c2  ? ctrl2_reg :
                      sel_st  ? stat_word :
                                16'h0000;

  // Counter parked while idle so the first period is whole
  assign div_clr      = tick | (state_reg == sfmc_pkg::SFMC_IDLE);
  assign div_cnt_next = div_clr ? 9'h000 : 9'(div_cnt_reg + 9'h001);
  assign last_bit     = (5'(bit_cnt_reg + 5'h01) == frame_bits);

  always_comb begin
    // Pulses drop unless a state holds them
    state_next    = state_reg;
    bit_cnt_next  = bit_cnt_reg;
    sync_out_next = 1'b0;
    start_next    = 1'b0;
    case (state_reg)
      sfmc_pkg::SFMC_IDLE: begin
        // master starts on request, slave on sync edge
        if (master && frame_req) begin
          state_next    = cfg.sync_edge ? sfmc_pkg::SFMC_SHIFT : sfmc_pkg::SFMC_LEAD;
          sync_out_next = 1'b1;
          start_next    = cfg.sync_edge;
          bit_cnt_next  = 5'h00;
        end else if (cfg.frm_en && cfg.sync_dir && sync_edge_in) begin
          state_next   = cfg.sync_edge ? sfmc_pkg::SFMC_SHIFT : sfmc_pkg::SFMC_LEAD;
          start_next   = cfg.sync_edge;
          bit_cnt_next = 5'h00;
        end
      end
      sfmc_pkg::SFMC_LEAD: begin
        sync_out_next = master & ~tick;
        if (tick) begin
          state_next = sfmc_pkg::SFMC_SHIFT;
          start_next = 1'b1;
        end
      end
      sfmc_pkg::SFMC_SHIFT: begin
        sync_out_next = master & cfg.sync_edge & (bit_cnt_reg == 5'h00) & ~tick;
        if (tick) begin
          bit_cnt_next = 5'(bit_cnt_reg + 5'h01);
          if (last_bit) begin
            state_next = sfmc_pkg::SFMC_IDLE;
          end
        end
      end
      default: begin
        // Unused code falls back to idle
        state_next = sfmc_pkg::SFMC_IDLE;
      end
    endcase
    if (!cfg.frm_en) begin
      state_next    = sfmc_pkg::SFMC_IDLE;
      sync_out_next = 1'b0;
      start_next    = 1'b0;
    end
  end

  // Pin is asynchronous: two flops, third only for edge detect
  always_ff @(posedge clk_sys) begin
    sync_s1_reg <= sync_pin_in;
    sync_s2_reg <= sync_s1_reg;
    sync_s3_reg <= sync_s2_reg;
  end

  // Registers and state, synchronous reset
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      ctrl1_reg    <= `SFMC_CTRL1_RST;
      ctrl2_reg    <= `SFMC_CTRL2_RST;
      div_cnt_reg  <= 9'h000;
      bit_cnt_reg  <= 5'h00;
      sync_out_reg <= 1'b0;
      start_reg    <= 1'b0;
      rdata_reg    <= 16'h0000;
      state_reg    <= sfmc_pkg::SFMC_IDLE;
    end else begin
      ctrl1_reg    <= ctrl1_next;
      ctrl2_reg    <= ctrl2_next;
      div_cnt_reg  <= div_cnt_next;
      bit_cnt_reg  <= bit_cnt_next;
      sync_out_reg <= sync_out_next;
      start_reg    <= start_next;
      rdata_reg    <= rdata_next;
      state_reg    <= state_next;
    end
  end

endmodule

// [hdl/sfmc_defs.svh]
/*
  Constants for the framed-mode control block: register offsets, bit
  positions, reset values and prescale codes.
  Assumes inclusion by its bare name from the design and bench files.
*/
`ifndef SFMC_DEFS_SVH
`define SFMC_DEFS_SVH
`define SFMC_ADDR_W        4
`define SFMC_OFS_CTRL1     4'h0
`define SFMC_OFS_CTRL2     4'h4
`define SFMC_OFS_STAT      4'h8
`define SFMC_CTRL2_RST     16'h0000
`define SFMC_CTRL2_WMASK   16'he002
`define SFMC_CTRL1_RST     16'h0000
`define SFMC_CTRL1_WMASK   16'h051f
`define SFMC_BIT_FRAMED_EN 15
`define SFMC_BIT_DIR       14
`define SFMC_BIT_POL       13
`define SFMC_BIT_EDGE      1
`define SFMC_BIT_WORD16    10
`define SFMC_BIT_CLK_EDGE  8
`define SFMC_SPRE_LSB      2
`define SFMC_PPRE_LSB      0
`define SFMC_PPRE_64       2'h0
`define SFMC_PPRE_16       2'h1
`define SFMC_PPRE_4        2'h2
`define SFMC_DIV_64        9'h040
`define SFMC_DIV_16        9'h010
`define SFMC_DIV_4         9'h004
`define SFMC_DIV_1         9'h001
`define SFMC_BITS_16       5'h10
`define SFMC_BITS_8        5'h08
`endif

// [hdl/sfmc_pkg.sv]
/*
  Types for the framed-mode control block.
  Assumes the defs header sits on the include path.
*/
package sfmc_pkg;
  typedef struct packed {
    logic frm_en;
    logic sync_dir;
    logic sync_pol;
    logic sync_edge;
  } sfmc_cfg_s;

  typedef enum logic [1:0] {
    SFMC_IDLE  = 2'b00,
    SFMC_LEAD  = 2'b01,
    SFMC_SHIFT = 2'b10
  } sfmc_state_e;
endpackage

// [dv/sfmc_ctrl_props.sv]
/* Checker on the framed-mode control ports.
   Assumes one clock; bound onto sfmc_ctrl. */
`timescale 1ns/1ps
`include "sfmc_defs.svh"
module sfmc_ctrl_props (
  // Clock and reset
  input wire logic        clk_sys,
  input wire logic        rstn,
  // Register port
  input wire logic [3:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  // Sync pin and bit timing
  input wire logic        sync_pin_out,
  input wire logic        sync_pin_oe,
  input wire logic        bit_tick,
  input wire logic        frame_start,
  input wire logic [4:0]  frame_bits
);
  logic [15:0] c1, c2;
  logic [9:0]  gap, act, per;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  assign per = (c1[1] ? (c1[0] ? 10'h001 : 10'h004) : (c1[0] ? 10'h010 : 10'h040)) * (10'h008 - c1[4:2]);
  always_ff @(posedge clk_sys) begin
    c1  <= !rstn ? 16'h0000 : (reg_wr && reg_addr == `SFMC_OFS_CTRL1) ? reg_wdata & `SFMC_CTRL1_WMASK : c1;
    c2  <= !rstn ? 16'h0000 : (reg_wr && reg_addr == `SFMC_OFS_CTRL2) ? reg_wdata & `SFMC_CTRL2_WMASK : c2;
    gap <= (!rstn || bit_tick) ? 10'h000 : gap + {9'h000, gap != 10'h3ff};
    act <= (sync_pin_oe && sync_pin_out == c2[13]) ? act + 10'h001 : 10'h000;
  end
  property p_oe; sync_pin_oe == (c2[15] && !c2[14]); endproperty
  a_oe: assert property (p_oe) else $error("oe");
  property p_lead; frame_start && sync_pin_oe && !c2[1] |-> act == per && sync_pin_out != c2[13]; endproperty
  a_lead: assert property (p_lead) else $error("lead");
  property p_coin; frame_start && sync_pin_oe && c2[1] |-> sync_pin_out == c2[13]; endproperty
  a_coin: assert property (p_coin) else $error("coin");
  property p_len; sync_pin_oe && sync_pin_out == c2[13] |-> act < per; endproperty
  a_len: assert property (p_len) else $error("len");
  property p_tick; bit_tick && gap < per |-> gap == per - 10'h001; endproperty
  a_tick: assert property (p_tick) else $error("tick");
  property p_bits; frame_bits == (c1[`SFMC_BIT_WORD16] ? `SFMC_BITS_16 : `SFMC_BITS_8); endproperty
  a_bits: assert property (p_bits) else $error("bits");
  property p_rd; reg_rd && reg_addr == `SFMC_OFS_CTRL2 |=> reg_rdata == $past(c2); endproperty
  a_rd: assert property (p_rd) else $error("rd");
  c_m: cover property (frame_start && sync_pin_oe && !c2[1]);
  c_c: cover property (frame_start && sync_pin_oe && c2[1]);
  c_s: cover property (frame_start && !sync_pin_oe);
endmodule
bind sfmc_ctrl sfmc_ctrl_props i_props (
  .clk_sys      (clk_sys),
  .rstn         (rstn),
  .reg_addr     (reg_addr),
  .reg_wdata    (reg_wdata),
  .reg_wr       (reg_wr),
  .reg_rd       (reg_rd),
  .reg_rdata    (reg_rdata),
  .sync_pin_out (sync_pin_out),
  .sync_pin_oe  (sync_pin_oe),
  .bit_tick     (bit_tick),
  .frame_start  (frame_start),
  .frame_bits   (frame_bits)
);

// [dv/sfmc_peer.sv]
/* Far-side peer: drives frame sync while the block is slave.
   Assumes one-cycle go pulses from the bench. */
`timescale 1ns/1ps
module sfmc_peer (
  // Control
  input wire logic       clk_sys,
  input wire logic       go,
  input wire logic       pol,
  input wire logic [9:0] len,
  // Pin
  output logic           sync_out
);
  logic [9:0] cnt = 10'h000;
  always @(posedge clk_sys)
    cnt <= go ? len : cnt - {9'h000, cnt != 10'h000};
  assign sync_out = (cnt != 10'h000) ? pol : !pol;
endmodule

// [dv/spi_framed_mode_control_tb.sv]
/* Bench: register access, master and slave frames.
   Assumes the defs header on the include path. */
`timescale 1ns/1ps
`include "sfmc_defs.svh"
module spi_framed_mode_control_tb;
  logic        clk_sys = 1'h0, rstn = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0, frame_req = 1'h0, go = 1'h0;
  logic        sync_pin_out, sync_pin_oe, bit_tick, frame_start, peer, pol = 1'h0;
  logic [3:0]  reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata, c1v;
  logic [4:0]  frame_bits;
  int          mismatches = 0, compares = 0, n, per;
  always #2.5 clk_sys = ~clk_sys;
  sfmc_ctrl i_dut (
    .clk_sys      (clk_sys),
    .rstn         (rstn),
    .reg_addr     (reg_addr),
    .reg_wdata    (reg_wdata),
    .reg_wr       (reg_wr),
    .reg_rd       (reg_rd),
    .reg_rdata    (reg_rdata),
    .frame_req    (frame_req),
    .sync_pin_in  (sync_pin_oe ? sync_pin_out : peer),
    .sync_pin_out (sync_pin_out),
    .sync_pin_oe  (sync_pin_oe),
    .bit_tick     (bit_tick),
    .frame_start  (frame_start),
    .frame_bits   (frame_bits)
  );
  sfmc_peer i_peer (.clk_sys(clk_sys), .go(go), .pol(pol), .len(10'h004), .sync_out(peer));
  task tally_and_finish;
    $display("mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input logic [15:0] got, exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %0t got %h want %h", $time, got, exp);
    end
  endtask
  task bus(input logic w, input logic [3:0] a, input logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= w;
    reg_rd <= !w;
    @(posedge clk_sys);
    reg_wr <= 1'h0;
    reg_rd <= 1'h0;
    #1 if (!w) chk(reg_rdata, d);
    @(posedge clk_sys);
  endtask
  task frame(input logic m, input logic [4:0] b);
    frame_req <= m;
    go <= !m;
    @(posedge clk_sys);
    frame_req <= 1'h0;
    go <= 1'h0;
    for (n = 0; frame_start !== 1'h1; n++) begin
      @(negedge clk_sys);
      if (n > 3000) begin
        mismatches++;
        tally_and_finish();
      end
    end
    n = 0;
    repeat ((b + 2) * per) begin
      @(negedge clk_sys);
      n += bit_tick;
    end
    chk(n[15:0], {11'h000, b});
    @(posedge clk_sys);
  endtask
  initial begin
    repeat (8) @(posedge clk_sys);
    rstn <= 1'h1;
    chk(sync_pin_out, 1'h1);
    bus(1'h0, `SFMC_OFS_CTRL1, `SFMC_CTRL1_RST);
    bus(1'h0, `SFMC_OFS_CTRL2, `SFMC_CTRL2_RST);
    bus(1'h1, `SFMC_OFS_CTRL2, 16'hfffe);
    bus(1'h0, `SFMC_OFS_CTRL2, 16'he002);
    bus(1'h0, 4'hc, 16'h0000);
    // Slave, active high, peer idles high: sync seen active, not busy
    bus(1'h0, `SFMC_OFS_STAT, 16'h0008);
    chk(sync_pin_oe, 1'h0);
    for (int i = 0; i < 8; i++) begin
      per = (i == 0) ? 64 : (i == 1) ? 16 : (i == 3) ? 2 : 4;
      bus(1'h1, `SFMC_OFS_CTRL2, 16'h0000);
      pol <= i[1];
      // Primary 64, 16, 1:1 or 4; secondary 1:1, or 2:1 beside primary 1:1
      c1v = (i == 0) ? 16'h001c : (i == 1) ? 16'h041d : (i == 3) ? 16'h041b : 16'h041e;
      bus(1'h1, `SFMC_OFS_CTRL1, c1v);
      chk(frame_bits, (i == 0) ? 16'h0008 : 16'h0010);
      bus(1'h1, `SFMC_OFS_CTRL2, {1'h1, i[2], i[1], 11'h000, i[0], 1'h0});
      chk(sync_pin_oe, !i[2]);
      if (!i[2]) chk(sync_pin_out, !i[1]);
      frame(!i[2], (i == 0) ? 5'h08 : 5'h10);
    end
    bus(1'h1, `SFMC_OFS_CTRL2, 16'h0000);
    chk(sync_pin_oe, 1'h0);
    tally_and_finish();
  end
endmodule
